// ===== sim/bcg_unit_monitor.sv
`include "bcg_defs.vh"

// ------
// port checker for the base clock unit
// ------
module bcg_mon #(
  parameter PLL_LOCK_CYCLES = 10000
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // register port
  input wire [7:0] addr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  // sources
  input wire ring_osc_in,
  input wire xtal_osc_in,
  // pll
  input wire pll_ref_clk_out,
  input wire pll_powerdown_out,
  input wire pll_fb_clk_out,
  input wire pll_lock_out,
  // base clocks
  input wire [11:0] base_clk_out
);
  logic [15:0] up_q;
  logic [1:0] age_q;

  // cycles since power-down cleared; saturates so it cannot wrap into a false low count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      up_q <= 16'h0;
      age_q <= 2'h0;
    end else begin
      if (pll_powerdown_out) begin
        up_q <= 16'h0;
      end else if (up_q != 16'hffff) begin
        up_q <= up_q + 16'h1;
      end
      if (age_q != 2'h3) begin
        age_q <= age_q + 2'h1;
      end
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  rsvd_base_low_a: assert property (base_clk_out[10] == 1'b0)
    else $error("reserved base clock not low");
  safe_from_ring_a: assert property ((base_clk_out[0] || base_clk_out[2]) |-> $past(ring_osc_in))
    else $error("safe or control clock not from ring");
  pd_no_lock_a: assert property (pll_powerdown_out |-> !pll_lock_out)
    else $error("lock while powered down");
  pd_fb_low_a: assert property (pll_powerdown_out [*3] |-> !pll_fb_clk_out)
    else $error("feedback clock runs in power-down");
  lock_wait_a: assert property ($rose(pll_lock_out) |-> up_q >= PLL_LOCK_CYCLES)
    else $error("lock came too early");
  ref_from_osc_a: assert property (pll_ref_clk_out |-> $past(ring_osc_in) || $past(xtal_osc_in))
    else $error("pll reference not from an oscillator");
  rsvd_read_a: assert property ($past(rd_in) && $past(addr_in) == 8'h28 |-> rdata_out == 32'h0)
    else $error("reserved channel reads nonzero");
  safe_sel_a: assert property ($past(rd_in) && ($past(addr_in) == 8'h00 ||
    $past(addr_in) == 8'h08) |-> rdata_out[3:0] == 4'h0)
    else $error("safe or control select left ring");
  absent_start_a: assert property ($past(rd_in) &&
    $past(addr_in) == `BCG_ADDR_STAT && age_q == 2'h1 |-> rdata_out[11:0] == 12'h0)
    else $error("source present right after reset");
  read_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside its cycle");
endmodule

bind bcg_unit bcg_mon #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) bcg_mon_inst (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .addr_in(addr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .ring_osc_in(ring_osc_in),
  .xtal_osc_in(xtal_osc_in),
  .pll_ref_clk_out(pll_ref_clk_out),
  .pll_powerdown_out(pll_powerdown_out),
  .pll_fb_clk_out(pll_fb_clk_out),
  .pll_lock_out(pll_lock_out),
  .base_clk_out(base_clk_out)
);

// ===== sim/tb.sv
`include "bcg_defs.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in;
  logic rst_in;
  logic wr_in;
  logic rd_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in;
  logic [2:0] tc_q;
  logic [11:0] on_q;
  logic xtal_d;
  int err_total;
  int comparisons;
  int n;
  wire [31:0] rdata_out;
  wire pll_ref_clk_out;
  wire pll_powerdown_out;
  wire pll_fb_clk_out;
  wire pll_lock_out;
  wire [6:0] fractional_divider_src_clk_out;
  wire [11:0] base_clk_out;
  // ------
  // sources: ring never stops, the others are gated per test
  // ------
  wire ring_osc_in = tc_q[0];
  wire xtal_osc_in = on_q[1] & tc_q[1];
  wire pll_cco_in = on_q[2] & tc_q[0];
  wire [1:0] pll_phase_in = {2{pll_cco_in}};
  wire [6:0] fractional_divider_clk_in = on_q[11:5] & {7{tc_q[2]}};

  // short lock count keeps the pll scenarios brief
  bcg_unit #(.PLL_LOCK_CYCLES(20)) bcg_unit_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .ring_osc_in(ring_osc_in),
    .xtal_osc_in(xtal_osc_in),
    .pll_cco_in(pll_cco_in),
    .pll_phase_in(pll_phase_in),
    .pll_ref_clk_out(pll_ref_clk_out),
    .pll_powerdown_out(pll_powerdown_out),
    .pll_fb_clk_out(pll_fb_clk_out),
    .pll_lock_out(pll_lock_out),
    .fractional_divider_clk_in(fractional_divider_clk_in),
    .fractional_divider_src_clk_out(fractional_divider_src_clk_out),
    .base_clk_out(base_clk_out)
  );

  // clock and source pattern; xtal_d is the crystal level seen at the last edge
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    tc_q <= tc_q + 3'h1;
    xtal_d <= xtal_osc_in;
  end

  // ------
  // bus and compare helpers
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look just after that edge
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out & m, e);
  endtask
  task automatic wait_lock;
    n = 0;
    while (pll_lock_out !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      n++;
    end
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset;
    rst_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    addr_in <= `BCG_ADDR_STAT;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, 32'h0);
    rd(8'h04, 32'h10f, 32'h100);
    rd(8'h30, 32'h10f, 32'h100);
    rd(`BCG_ADDR_PLL, 32'hf00, 32'h0);
    rd(8'h28, 32'hffffffff, 32'h0);
    rd(8'h7c, 32'hffffffff, 32'h0);
  endtask
  task automatic t_sel;
    on_q <= 12'h002;
    repeat (40) @(posedge clk_in);
    // the crystal is confirmed running before the system clock moves onto it
    rd(`BCG_ADDR_STAT, 32'hfff, 32'h003);
    wr(8'h04, 32'h102);
    rd(8'h04, 32'h10f, 32'h100);
    wr(8'h04, 32'h00f);
    rd(8'h04, 32'h10f, 32'h000);
    wr(8'h00, 32'h101);
    rd(8'h00, 32'h10f, 32'h100);
    wr(8'h08, 32'h101);
    rd(8'h08, 32'h10f, 32'h100);
    wr(8'h04, 32'h101);
    rd(8'h04, 32'h10f, 32'h101);
    wr(8'h30, 32'h101);
    repeat (12) @(posedge clk_in);
    repeat (8) begin
      @(posedge clk_in);
      #1;
      chk(base_clk_out[1], xtal_d);
      chk(fractional_divider_src_clk_out[0], xtal_d);
    end
    on_q <= 12'hfe2;
    repeat (20) @(posedge clk_in);
    rd(`BCG_ADDR_STAT, 32'hfff, 32'hfe3);
    wr(8'h34, 32'h105);
    rd(8'h34, 32'h10f, 32'h100);
    wr(8'h0c, 32'h10b);
    rd(8'h0c, 32'h10f, 32'h10b);
    // a divider code is illegal for the pll, the other fields must still land
    wr(`BCG_ADDR_PLL, 32'h511);
    rd(`BCG_ADDR_PLL, 32'hf1f, 32'h011);
  endtask
  task automatic t_pll;
    on_q <= 12'hfe6;
    wr(`BCG_ADDR_PLL, 32'h112);
    wait_lock;
    chk(pll_lock_out, 1'b1);
    chk(32'(n >= 19), 32'h1);
    // gated phases need a rising edge plus a detector cycle after lock
    repeat (4) @(posedge clk_in);
    rd(`BCG_ADDR_STAT, 32'h1001c, 32'h1001c);
    wr(8'h04, 32'h103);
    rd(8'h04, 32'h10f, 32'h103);
    wr(8'h04, 32'h101);
    wr(`BCG_ADDR_PLL, 32'h113);
    #1;
    chk(pll_powerdown_out, 1'b1);
    chk(pll_lock_out, 1'b0);
    rd(`BCG_ADDR_PLL, 32'hf1f, 32'h113);
    wr(`BCG_ADDR_PLL, 32'h112);
    wait_lock;
    chk(pll_lock_out, 1'b1);
    wr(`BCG_ADDR_PLL, 32'h11a);
    rd(`BCG_ADDR_PLL, 32'hf1f, 32'h11a);
  endtask
  task automatic t_det;
    wr(`BCG_ADDR_EVT, 32'hffffffff);
    on_q <= 12'hfe4;
    repeat (24) @(posedge clk_in);
    rd(`BCG_ADDR_STAT, 32'h2, 32'h2);
    repeat (12) @(posedge clk_in);
    rd(`BCG_ADDR_STAT, 32'h2, 32'h0);
    rd(`BCG_ADDR_EVT, 32'h20002, 32'h20000);
    rd(8'h04, 32'h10f, 32'h101);
    wr(`BCG_ADDR_EVT, 32'h20000);
    rd(`BCG_ADDR_EVT, 32'h20000, 32'h0);
    on_q <= 12'hfe6;
    repeat (10) @(posedge clk_in);
    rd(`BCG_ADDR_EVT, 32'h2, 32'h2);
  endtask

  // ------
  // verdict
  // ------
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // whole run is well under a thousand cycles; this only cuts a hang short
  initial begin
    repeat (5000) @(posedge clk_in);
    err_total++;
    report_and_stop;
  end

  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h0;
    wdata_in = 32'h0;
    tc_q = 3'h0;
    on_q = 12'h002;
    xtal_d = 1'b0;
    err_total = 0;
    comparisons = 0;
    t_reset;
    t_sel;
    t_pll;
    t_det;
    t_reset;
    report_and_stop;
  end
endmodule

// ===== src/bcg_defs.vh
`ifndef BCG_DEFS_VH
`define BCG_DEFS_VH
// ----------------------------------------------------------------
// sizes and source codes
// ----------------------------------------------------------------
`define BCG_NUM_SRC 12
`define BCG_NUM_BASE 12
`define BCG_NUM_FRACTIONAL_DIVIDER 7
`define BCG_NUM_CH 19
`define BCG_SRC_RING 4'h0
`define BCG_SRC_XTAL 4'h1
`define BCG_SRC_PLL0 4'h2
`define BCG_SRC_PLL1 4'h3
`define BCG_SRC_PLL2 4'h4
`define BCG_SRC_FDIV0 4'h5
`define BCG_SRC_LAST 4'hb
// channel numbers: 0..11 base clocks, 12..18 divider inputs
`define BCG_CH_SAFE 5'h00
`define BCG_CH_SYS 5'h01
`define BCG_CH_CTRL 5'h02
`define BCG_CH_RSVD 5'h0a
`define BCG_CH_FDIV0 5'h0c
`define BCG_CH_LAST 5'h12
// ----------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------
`define BCG_ADDR_PLL 8'h50
`define BCG_ADDR_STAT 8'h54
`define BCG_ADDR_EVT 8'h58
`define BCG_SEL_MSB 3
`define BCG_SEL_LSB 0
`define BCG_EN_BIT 8
`define BCG_PLL_PD_BIT 0
`define BCG_PLL_DIR_BIT 1
`define BCG_PLL_PSEL_MSB 3
`define BCG_PLL_PSEL_LSB 2
`define BCG_PLL_TRI_BIT 4
`define BCG_PLL_SRC_MSB 11
`define BCG_PLL_SRC_LSB 8
`define BCG_STAT_LOCK_BIT 16
`define BCG_EVT_FALL_LSB 16
`define BCG_EN_RST 19'h7fbff
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BCG_DET_TIMEOUT 6'h20
`define BCG_STUCK_CYC 6'h20
`define BCG_CLK_PERIOD_NS 5
`define BCG_PLL_LOCK_NS 50000
`define BCG_ST_RUN 2'h0
`define BCG_ST_WAIT 2'h1
`define BCG_ST_HOLD 2'h2
`endif

// ===== src/bcg_det.v
`include "bcg_defs.vh"

// ----------------------------------------------------------------
// activity detector for one clock source
// ----------------------------------------------------------------
module bcg_det (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // sampled source level
  input wire src_in,
  // presence and change events
  output wire active_out,
  output wire rise_out,
  output wire fall_out
);
  reg prev_q;
  reg act_q;
  reg rise_q;
  reg fall_q;
  reg [5:0] cnt_q;
  reg act_d;
  wire edge_w = src_in & ~prev_q;

  // any rising edge marks present, a full timeout without one marks absent
  always @* begin
    act_d = act_q;
    if (edge_w) begin
      act_d = 1'b1;
    end else if (cnt_q == `BCG_DET_TIMEOUT - 6'h01) begin
      act_d = 1'b0;
    end
  end

  // counter starts saturated so every source reads absent out of reset
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= 1'b1; // a source stuck high must not look like an edge
      act_q <= 1'b0;
      cnt_q <= `BCG_DET_TIMEOUT;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      prev_q <= src_in;
      act_q <= act_d;
      if (edge_w) begin
        cnt_q <= 6'h00;
      end else if (cnt_q != `BCG_DET_TIMEOUT) begin
        cnt_q <= cnt_q + 6'h01;
      end
      rise_q <= act_d & ~act_q;
      fall_q <= ~act_d & act_q;
    end
  end

  assign active_out = act_q;
  assign rise_out = rise_q;
  assign fall_out = fall_q;
endmodule

// ===== src/bcg_unit.v
`include "bcg_defs.vh"

module bcg_unit #(
  parameter PLL_LOCK_CYCLES = `BCG_PLL_LOCK_NS / `BCG_CLK_PERIOD_NS,
  parameter LOCK_W = 16,
  parameter FB_DIV = 8'h04
) (
  // slow control clock and reset
  input wire clk_in,
  input wire rst_in,
  // register port
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output wire [31:0] rdata_out,
  // primary sources
  input wire ring_osc_in,
  input wire xtal_osc_in,
  // pll analog section
  input wire pll_cco_in,
  input wire [1:0] pll_phase_in,
  output wire pll_ref_clk_out,
  output wire pll_powerdown_out,
  output wire pll_fb_clk_out,
  output wire pll_lock_out,
  // fractional dividers
  input wire [6:0] fractional_divider_clk_in,
  output wire [6:0] fractional_divider_src_clk_out,
  // base clocks
  output wire [11:0] base_clk_out
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [3:0] sel_q [0:18];
  reg [18:0] en_q;
  reg pd_q;
  reg dir_q;
  reg [1:0] psel_q;
  reg tri_q;
  reg [3:0] pll_src_q;
  reg [27:0] evt_q;
  reg [31:0] rdata_q;
  reg relock_q;
  // pll state
  reg cco_prev_q;
  reg [3:0] div_cnt_q;
  reg [LOCK_W-1:0] lock_cnt_q;
  reg lock_q;
  reg pll_out_q;
  reg pll_prev_q;
  reg [7:0] fb_cnt_q;
  reg fb_q;
  reg [1:0] ph_q;
  reg ref_q;
  integer i;

  wire [11:0] pres_w;
  wire [11:0] rise_w;
  wire [11:0] fall_w;
  wire [18:0] ch_out_w;
  wire [5:0] widx_w = addr_in[7:2];
  wire ch_hit_w = (widx_w <= {1'b0, `BCG_CH_LAST}) && (addr_in[1:0] == 2'h0);
  wire [3:0] wsel_w = wdata_in[`BCG_SEL_MSB:`BCG_SEL_LSB];
  wire [3:0] wpll_w = wdata_in[`BCG_PLL_SRC_MSB:`BCG_PLL_SRC_LSB];
  // power-down as it stands after this edge, so lock drops on the same edge
  // instead of trailing the power-down bit by one cycle
  wire pll_wr_w = wr_in && (addr_in == `BCG_ADDR_PLL);
  wire pd_d_w = pll_wr_w ? wdata_in[`BCG_PLL_PD_BIT] : pd_q;

  // source vector in code order: ring, crystal, pll output and its two phases, dividers
  wire [11:0] src_w = {fractional_divider_clk_in, ph_q, pll_out_q, xtal_osc_in, ring_osc_in};

  // ----------------------------------------------------------------
  // select legality
  // ----------------------------------------------------------------
  // a code must exist, be present, and suit the channel it is written to
  function legal;
    input [4:0] ch;
    input [3:0] code;
    input [11:0] pres;
    begin
      if (code > `BCG_SRC_LAST) begin
        legal = 1'b0;
      end else if (!pres[code]) begin
        legal = 1'b0;
      end else if (ch == `BCG_CH_SAFE || ch == `BCG_CH_CTRL) begin
        legal = (code == `BCG_SRC_RING);
      end else if (ch == `BCG_CH_RSVD) begin
        legal = 1'b0;
      end else if (ch >= `BCG_CH_FDIV0) begin
        legal = (code <= `BCG_SRC_PLL2);
      end else begin
        legal = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // activity detectors, one per source
  // ----------------------------------------------------------------
  genvar s;
  generate
    for (s = 0; s < `BCG_NUM_SRC; s = s + 1) begin : g_det
      bcg_det u_det (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .src_in(src_w[s]),
        .active_out(pres_w[s]),
        .rise_out(rise_w[s]),
        .fall_out(fall_w[s])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // enable fields land on every channel but the reserved one, select fields only when legal
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (i = 0; i < `BCG_NUM_CH; i = i + 1) begin
        sel_q[i] <= `BCG_SRC_RING;
      end
      en_q <= `BCG_EN_RST;
      pd_q <= 1'b0;
      dir_q <= 1'b0;
      psel_q <= 2'h0;
      tri_q <= 1'b0;
      pll_src_q <= `BCG_SRC_RING;
      relock_q <= 1'b0;
    end else begin
      relock_q <= 1'b0;
      if (wr_in && ch_hit_w && widx_w[4:0] != `BCG_CH_RSVD) begin
        en_q[widx_w[4:0]] <= wdata_in[`BCG_EN_BIT];
        if (legal(widx_w[4:0], wsel_w, pres_w)) begin
          sel_q[widx_w[4:0]] <= wsel_w;
        end
      end
      if (wr_in && addr_in == `BCG_ADDR_PLL) begin
        pd_q <= wdata_in[`BCG_PLL_PD_BIT];
        dir_q <= wdata_in[`BCG_PLL_DIR_BIT];
        psel_q <= wdata_in[`BCG_PLL_PSEL_MSB:`BCG_PLL_PSEL_LSB];
        tri_q <= wdata_in[`BCG_PLL_TRI_BIT];
        // only the oscillators may feed the pll; others leave it unchanged
        if ((wpll_w == `BCG_SRC_XTAL || wpll_w == `BCG_SRC_RING) && pres_w[wpll_w]) begin
          pll_src_q <= wpll_w;
          relock_q <= (wpll_w != pll_src_q);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  // write one to clear; a new event in the same cycle wins over the clear
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      evt_q <= 28'h0000000;
    end else begin
      if (wr_in && addr_in == `BCG_ADDR_EVT) begin
        evt_q <= (evt_q & ~wdata_in[27:0]) | {fall_w, 4'h0, rise_w};
      end else begin
        evt_q <= evt_q | {fall_w, 4'h0, rise_w};
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // data stands for exactly one cycle after the strobe, zero otherwise
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h00000000;
    end else if (!rd_in) begin
      rdata_q <= 32'h00000000;
    end else if (ch_hit_w) begin
      rdata_q <= {23'h000000, en_q[widx_w[4:0]], 4'h0, sel_q[widx_w[4:0]]};
    end else if (addr_in == `BCG_ADDR_PLL) begin
      rdata_q <= {20'h00000, pll_src_q, 3'h0, tri_q, psel_q, dir_q, pd_q};
    end else if (addr_in == `BCG_ADDR_STAT) begin
      rdata_q <= {15'h0000, lock_q, 4'h0, pres_w};
    end else if (addr_in == `BCG_ADDR_EVT) begin
      rdata_q <= {4'h0, evt_q};
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // pll model: reference, lock, post divider, feedback, phases
  // ----------------------------------------------------------------
  // lock is a simple timer; a real loop would report it from the analog side
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_cnt_q <= {LOCK_W{1'b0}};
      lock_q <= 1'b0;
      ref_q <= 1'b0;
    end else begin
      ref_q <= src_w[pll_src_q];
      // counting restarts only once power-down has really cleared
      if (pd_q || pd_d_w || relock_q || !pres_w[pll_src_q]) begin
        lock_cnt_q <= {LOCK_W{1'b0}};
        lock_q <= 1'b0;
      end else if (lock_cnt_q == PLL_LOCK_CYCLES[LOCK_W-1:0] - 1'b1) begin
        lock_q <= 1'b1;
      end else begin
        lock_cnt_q <= lock_cnt_q + 1'b1;
      end
    end
  end

  // post divider counts oscillator edges; bit n gives divide by 2^(n+1)
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cco_prev_q <= 1'b0;
      div_cnt_q <= 4'h0;
      pll_out_q <= 1'b0;
      ph_q <= 2'h0;
    end else begin
      cco_prev_q <= pll_cco_in;
      if (pd_q) begin
        div_cnt_q <= 4'h0;
      end else if (pll_cco_in && !cco_prev_q) begin
        div_cnt_q <= div_cnt_q + 4'h1;
      end
      // output stays low while unlocked or powered down
      pll_out_q <= lock_q & ~pd_q & (dir_q ? pll_cco_in : div_cnt_q[psel_q]);
      ph_q <= {2{lock_q & tri_q & ~pd_q}} & pll_phase_in;
    end
  end

  // feedback divider forms the comparison clock from the pll output
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pll_prev_q <= 1'b0;
      fb_cnt_q <= 8'h00;
      fb_q <= 1'b0;
    end else begin
      pll_prev_q <= pll_out_q;
      if (pd_q) begin
        fb_cnt_q <= 8'h00;
      end else if (pll_out_q && !pll_prev_q) begin
        fb_cnt_q <= (fb_cnt_q >= FB_DIV - 8'h01) ? 8'h00 : fb_cnt_q + 8'h01;
      end
      fb_q <= (fb_cnt_q < {1'b0, FB_DIV[7:1]}) & ~pd_q;
    end
  end

  // ----------------------------------------------------------------
  // glitch-free selectors: 12 base outputs then 7 divider inputs
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `BCG_NUM_CH; g = g + 1) begin : g_ch
      reg [1:0] st_q;
      reg [3:0] cur_q;
      reg [5:0] tmr_q;
      reg out_q;
      // the old clock is let fall before the new one is taken; an absent
      // source already selected keeps feeding, only its status bit and its event report it
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          st_q <= `BCG_ST_RUN;
          cur_q <= `BCG_SRC_RING;
          tmr_q <= 6'h00;
          out_q <= 1'b0;
        end else begin
          case (st_q)
            `BCG_ST_RUN: begin
              out_q <= src_w[cur_q] & en_q[g];
              tmr_q <= 6'h00;
              if (sel_q[g] != cur_q) begin
                st_q <= `BCG_ST_WAIT;
              end
            end
            `BCG_ST_WAIT: begin
              tmr_q <= tmr_q + 6'h01;
              if (!out_q || tmr_q == `BCG_STUCK_CYC - 6'h01) begin
                out_q <= 1'b0;
                st_q <= `BCG_ST_HOLD;
              end else begin
                out_q <= src_w[cur_q] & en_q[g];
              end
            end
            `BCG_ST_HOLD: begin
              // one low cycle for the handover, then the new source
              out_q <= 1'b0;
              cur_q <= sel_q[g];
              st_q <= `BCG_ST_RUN;
            end
            default: begin
              st_q <= `BCG_ST_RUN;
              out_q <= 1'b0;
            end
          endcase
        end
      end
      assign ch_out_w[g] = out_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign base_clk_out = ch_out_w[11:0];
  assign fractional_divider_src_clk_out = ch_out_w[18:12];
  assign rdata_out = rdata_q;
  assign pll_ref_clk_out = ref_q;
  assign pll_powerdown_out = pd_q;
  assign pll_fb_clk_out = fb_q;
  assign pll_lock_out = lock_q;
endmodule
